// file: mcup_map.vh
// Purpose: Constants for the multi-channel serial port bank
// Assumes: Included by mcup_port.v only
// Notes: Register select codes are {register_select_high, register_select_low}
`ifndef MCUP_MAP_VH
`define MCUP_MAP_VH
// Register select codes
`define MCUP_SEL_DATA 2'b00
`define MCUP_SEL_STATUS 2'b01
`define MCUP_SEL_MODE 2'b10
`define MCUP_SEL_CMD 2'b11
// Status bit positions
`define MCUP_ST_TRANSMIT_READY_OUT 0
`define MCUP_ST_RECEIVE_READY_OUT 1
`define MCUP_ST_TXEMPTY 2
`define MCUP_ST_OVERRUN 4
`define MCUP_ST_FRAMING 5
`define MCUP_ST_DSR 7
// Command bit positions
`define MCUP_CMD_TXEN 0
`define MCUP_CMD_DTR 1
`define MCUP_CMD_RXEN 2
`define MCUP_CMD_ERRCLR 4
`define MCUP_CMD_RTS 5
// Channel numbers
`define MCUP_CH_CONSOLE 0
`define MCUP_CH_MODEM 1
`define MCUP_CH_PRINTER 2
`define MCUP_CHANNELS 6
// Mode fields: mode 1 bits 1:0 zero selects synchronous, mode 2 bits 2:0 pick the rate
`define MCUP_MODE_SYNC 2'b00
`define MCUP_SYNC_FIRST 2'b00
`define MCUP_SYNC_SECOND 2'b01
`define MCUP_SYNC_ESCAPE 2'b10
// Baud reference and oversampling
`define MCUP_REF_HZ 5068800
`define MCUP_OVERSAMPLE 16
`define MCUP_OS_LAST 4'hf
`define MCUP_OS_HALF 4'h7
`define MCUP_BITS_ASYNC 4'h9
`define MCUP_BITS_SYNC 4'h7
`define MCUP_LAST_DATA_BIT 3'h7
// Selectable line rates
`define MCUP_BAUD_0 50
`define MCUP_BAUD_1 110
`define MCUP_BAUD_2 300
`define MCUP_BAUD_3 600
`define MCUP_BAUD_4 1200
`define MCUP_BAUD_5 2400
`define MCUP_BAUD_6 4800
`define MCUP_BAUD_7 9600
// Run indicator hold time and clock period
`define MCUP_RUN_HOLD_NS 50000000
`define MCUP_CLK_NS 4
`endif

// file: mcup_peer.sv
// Purpose: Serial terminal on the far side of the channel lines
// Assumes: Eight data bits, no parity, one stop bit, low bit first, idle high
// Notes: Bit time matches the sped-up reference at the fastest rate
module mcup_peer #(
  parameter int BIT_NS = 4224
) (
  input wire [5:0] line_from_dut,
  output logic [5:0] line_to_dut
);
  timeunit 1ns;
  timeprecision 100ps;
  initial line_to_dut = 6'h3f;
  // Sends start bit, data and stop bit
  task automatic send_char(input int ch, input logic [7:0] data);
    logic [9:0] f;
    f = {1'b1, data, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_to_dut[ch] = f[i];
      #(BIT_NS);
    end
  endtask
  // Waits for a start bit, samples mid-cell, checks stop bit
  task automatic get_char(input int ch, output logic [7:0] data, output logic ok);
    int t;
    data = 8'h00;
    for (t = 0; t < 20000 && line_from_dut[ch] !== 1'b0; t++)
      #4;
    #(BIT_NS * 3 / 2);
    for (int i = 0; i < 8; i++) begin
      data[i] = line_from_dut[ch];
      #(BIT_NS);
    end
    ok = (line_from_dut[ch] === 1'b1) && (t < 20000);
  endtask
  // Holds one line at a level for clocked synchronous traffic
  task automatic drive(input int ch, input logic v);
    line_to_dut[ch] = v;
  endtask
endmodule

// file: mcup_port.v
// Purpose: Bank of six serial receiver-transmitters on an 8-bit I/O bus, with strap and indicator logic
// Assumes: All inputs synchronous to CLOCK; only one chip enable low at a time
// Notes: Channel 0 console, 1 modem, 2 printer, 3 to 5 optional terminals
// Overview of operation
// - Direction low reads received data; direction high writes transmit data.
// - Select 01 reads status, writes first sync, second sync or escape char.
// - Select 10 reads or writes the two mode registers.
// - Select 11 reads or writes the command register.
// - Master reset clears every channel register except the transmit line and shifter, which it sets to ones.
// - Baud generators run from the shared 5.0688 MHz reference clock.
// - Status bit seven reads the inverse of data-set-ready.
// - Terminal-ready output is the inverse of command bit one.
// - Request-to-send output is the inverse of command bit five.
// - Receive-ready output is inverse of status bit one, low when data waits.
// - Transmit-ready output is inverse of status bit zero, low when holding empty.
// - Modem channel uses external receive and transmit clocks in synchronous mode.
// - Console data-set-ready strap high permits autobaud, low disables it.
// - Console serial input is also routed to the processor serial input.
// - Modem data-set-ready strap low selects manufacturing test mode.
// - Every channel, modem and printer included, gates transmission on clear-to-send.
// - Printer takes data-set-ready from printer ready; its outputs drive indicators.
// - Indicator one lit while printer output one low; two likewise.
// - Bus activity falling edge retriggers the run indicator one-shot.
// - Master reset clears the run indicator one-shot.
// - Data bus drives toward host while read strobe and any chip enable are low.
`include "mcup_map.vh"
module mcup_port #(
  parameter RUN_HOLD_CYCLES = `MCUP_RUN_HOLD_NS / `MCUP_CLK_NS
) (
  input wire CLOCK,
  input wire SYS_RST,
  input wire [5:0] CHIP_ENABLE_N,
  input wire DIRECTION_SELECT,
  input wire REGISTER_SELECT_HIGH,
  input wire REGISTER_SELECT_LOW,
  input wire READ_STROBE_N,
  input wire WRITE_STROBE_N,
  input wire [7:0] CHANNEL_DATA_BUS_IN,
  output reg [7:0] CHANNEL_DATA_BUS_OUT,
  output wire CHANNEL_DATA_BUS_OE,
  input wire BAUD_REFERENCE_CLOCK,
  input wire SYNC_RECEIVE_CLOCK,
  input wire SYNC_TRANSMIT_CLOCK,
  input wire [5:0] SERIAL_IN,
  output wire [5:0] SERIAL_OUT,
  input wire [5:0] DATA_SET_READY,
  input wire [5:0] CLEAR_TO_SEND_N,
  output wire [5:0] TERMINAL_READY_OUT,
  output wire [5:0] REQUEST_TO_SEND_OUT,
  output wire [5:0] RECEIVE_READY_OUT,
  output wire [5:0] TRANSMIT_READY_OUT,
  output wire PROCESSOR_SERIAL_IN,
  output wire AUTOBAUD_ENABLE,
  output wire FACTORY_TEST_MODE,
  output wire INDICATOR_ONE_LIT,
  output wire INDICATOR_TWO_LIT,
  input wire BUS_ACTIVITY_PULSE_N,
  output wire RUN_INDICATOR
);

  localparam RX_IDLE = 2'b00;
  localparam RX_START = 2'b01;
  localparam RX_DATA = 2'b10;
  localparam RX_STOP = 2'b11;

  // Reference clock periods per oversample tick for a rate index
  function [12:0] baud_div;
    input [2:0] idx;
    integer rate;
    integer q;
    begin
      case (idx)
        3'h0: rate = `MCUP_BAUD_0;
        3'h1: rate = `MCUP_BAUD_1;
        3'h2: rate = `MCUP_BAUD_2;
        3'h3: rate = `MCUP_BAUD_3;
        3'h4: rate = `MCUP_BAUD_4;
        3'h5: rate = `MCUP_BAUD_5;
        3'h6: rate = `MCUP_BAUD_6;
        default: rate = `MCUP_BAUD_7;
      endcase
      q = (`MCUP_REF_HZ / `MCUP_OVERSAMPLE) / rate;
      baud_div = q[12:0];
    end
  endfunction

  // Shared edge detectors for the reference and modem sync clocks
  reg ref_prev;
  reg rxc_prev;
  reg txc_prev;
  reg act_prev;
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      ref_prev <= 1'b0;
      rxc_prev <= 1'b0;
      txc_prev <= 1'b0;
      act_prev <= 1'b1;
    end else begin
      ref_prev <= BAUD_REFERENCE_CLOCK;
      rxc_prev <= SYNC_RECEIVE_CLOCK;
      txc_prev <= SYNC_TRANSMIT_CLOCK;
      act_prev <= BUS_ACTIVITY_PULSE_N;
    end
  end
  wire ref_tick = BAUD_REFERENCE_CLOCK & ~ref_prev;
  wire rxc_tick = SYNC_RECEIVE_CLOCK & ~rxc_prev;
  wire txc_tick = SYNC_TRANSMIT_CLOCK & ~txc_prev;

  wire [47:0] rd_flat;
  wire [5:0] rd_start;

  genvar i;
  generate
    for (i = 0; i < `MCUP_CHANNELS; i = i + 1) begin : ch
      reg [7:0] rx_hold, tx_hold, sync_first, sync_second, escape_char;
      reg [7:0] mode_one, mode_two, cmd;
      reg mode_ptr, rx_full, tx_full, overrun, framing, acc_prev;
      reg [1:0] sync_ptr, rx_state;
      reg [12:0] div_cnt;
      reg [3:0] rx_cnt, tx_cnt, tx_left;
      reg [2:0] rx_bits;
      reg [7:0] rx_shift;
      reg [8:0] tx_shift;
      reg tx_busy, tx_line;
      reg [7:0] rd_val;
      wire acc = ~CHIP_ENABLE_N[i] & (~READ_STROBE_N | ~WRITE_STROBE_N);
      wire start = acc & ~acc_prev;
      wire rd = start & ~DIRECTION_SELECT;
      wire wr = start & DIRECTION_SELECT;
      wire [1:0] sel = {REGISTER_SELECT_HIGH, REGISTER_SELECT_LOW};
      wire sync_mode = (i == `MCUP_CH_MODEM) && (mode_one[1:0] == `MCUP_MODE_SYNC);
      wire os_tick = ref_tick && (div_cnt == baud_div(mode_two[2:0]) - 13'h1);
      wire rx_bit = sync_mode ? rxc_tick : (os_tick && rx_cnt == `MCUP_OS_LAST);
      wire tx_bit = sync_mode ? txc_tick : (os_tick && tx_cnt == `MCUP_OS_LAST);
      wire rx_load = rx_bit && ((rx_state == RX_STOP) ||
                      (sync_mode && rx_state == RX_DATA && rx_bits == `MCUP_LAST_DATA_BIT));
      wire [7:0] rx_char = sync_mode ? {SERIAL_IN[i], rx_shift[7:1]} : rx_shift;
      wire tx_go = ~tx_busy & cmd[`MCUP_CMD_TXEN] & ~CLEAR_TO_SEND_N[i] & (tx_full | sync_mode);
      wire [7:0] status = {~DATA_SET_READY[i], 1'b0, framing, overrun, 1'b0,
                           ~tx_busy & ~tx_full, rx_full, ~tx_full};

      // Register reads for the shared data bus
      always @* begin
        case (sel)
          `MCUP_SEL_DATA: rd_val = rx_hold;
          `MCUP_SEL_STATUS: rd_val = status;
          `MCUP_SEL_MODE: rd_val = mode_ptr ? mode_two : mode_one;
          `MCUP_SEL_CMD: rd_val = cmd;
          default: rd_val = 8'h00;
        endcase
      end
      assign rd_flat[8*i+7:8*i] = rd_val;
      assign rd_start[i] = rd;

      // Host side registers and access side effects
      always @(posedge CLOCK) begin
        if (SYS_RST) begin
          acc_prev <= 1'b0;
          tx_hold <= 8'h00;
          sync_first <= 8'h00;
          sync_second <= 8'h00;
          escape_char <= 8'h00;
          mode_one <= 8'h00;
          mode_two <= 8'h00;
          cmd <= 8'h00;
          mode_ptr <= 1'b0;
          sync_ptr <= `MCUP_SYNC_FIRST;
        end else begin
          acc_prev <= acc;
          if (wr && sel == `MCUP_SEL_DATA)
            tx_hold <= CHANNEL_DATA_BUS_IN;
          // sync and escape chars in turn
          if (wr && sel == `MCUP_SEL_STATUS) begin
            case (sync_ptr)
              `MCUP_SYNC_FIRST: sync_first <= CHANNEL_DATA_BUS_IN;
              `MCUP_SYNC_SECOND: sync_second <= CHANNEL_DATA_BUS_IN;
              default: escape_char <= CHANNEL_DATA_BUS_IN;
            endcase
            sync_ptr <= (sync_ptr == `MCUP_SYNC_ESCAPE) ? `MCUP_SYNC_FIRST : sync_ptr + 2'b01;
          end
          if (start && sel == `MCUP_SEL_MODE) begin
            mode_ptr <= ~mode_ptr;
            if (wr && !mode_ptr)
              mode_one <= CHANNEL_DATA_BUS_IN;
            if (wr && mode_ptr)
              mode_two <= CHANNEL_DATA_BUS_IN;
          end
          if (wr && sel == `MCUP_SEL_CMD)
            cmd <= CHANNEL_DATA_BUS_IN;
          if (rd && sel == `MCUP_SEL_CMD) begin
            mode_ptr <= 1'b0;
            sync_ptr <= `MCUP_SYNC_FIRST;
          end
        end
      end

      // Baud divider and receiver
      always @(posedge CLOCK) begin
        if (SYS_RST) begin
          div_cnt <= 13'h0000;
          rx_state <= RX_IDLE;
          rx_cnt <= 4'h0;
          rx_bits <= 3'h0;
          rx_shift <= 8'h00;
          rx_hold <= 8'h00;
          rx_full <= 1'b0;
          overrun <= 1'b0;
          framing <= 1'b0;
        end else begin
          if (ref_tick)
            div_cnt <= os_tick ? 13'h0000 : div_cnt + 13'h0001;
          if (os_tick)
            rx_cnt <= rx_cnt + 4'h1;
          if (!cmd[`MCUP_CMD_RXEN]) begin
            rx_state <= RX_IDLE;
          end else begin
            case (rx_state)
              RX_IDLE: begin
                if (sync_mode) begin
                  rx_state <= RX_DATA;
                  rx_bits <= 3'h0;
                end else if (os_tick && !SERIAL_IN[i]) begin
                  rx_state <= RX_START;
                  rx_cnt <= 4'h0;
                end
              end
              RX_START: begin
                if (os_tick && rx_cnt == `MCUP_OS_HALF) begin
                  rx_state <= SERIAL_IN[i] ? RX_IDLE : RX_DATA;
                  rx_cnt <= 4'h0;
                  rx_bits <= 3'h0;
                end
              end
              RX_DATA: begin
                if (rx_bit) begin
                  rx_shift <= {SERIAL_IN[i], rx_shift[7:1]};
                  rx_bits <= rx_bits + 3'h1;
                  if (rx_bits == `MCUP_LAST_DATA_BIT && !sync_mode)
                    rx_state <= RX_STOP;
                end
              end
              RX_STOP: begin
                if (rx_bit)
                  rx_state <= RX_IDLE;
              end
              default: rx_state <= RX_IDLE;
            endcase
          end
          // Read of received data empties the holder; a new character wins
          if (rd && sel == `MCUP_SEL_DATA)
            rx_full <= 1'b0;
          // Error flags clear by command; a fresh error wins
          if (wr && sel == `MCUP_SEL_CMD && CHANNEL_DATA_BUS_IN[`MCUP_CMD_ERRCLR]) begin
            overrun <= 1'b0;
            framing <= 1'b0;
          end
          if (rx_load && cmd[`MCUP_CMD_RXEN]) begin
            rx_hold <= rx_char;
            rx_full <= 1'b1;
            if (rx_full && !(rd && sel == `MCUP_SEL_DATA))
              overrun <= 1'b1;
            if (!sync_mode && !SERIAL_IN[i])
              framing <= 1'b1;
          end
        end
      end

      // Transmitter
      always @(posedge CLOCK) begin
        if (SYS_RST) begin
          tx_full <= 1'b0;
          tx_busy <= 1'b0;
          tx_line <= 1'b1;
          tx_cnt <= 4'h0;
          tx_left <= 4'h0;
          tx_shift <= 9'h1ff;
        end else begin
          if (os_tick)
            tx_cnt <= tx_cnt + 4'h1;
          if (tx_go) begin
            tx_busy <= 1'b1;
            tx_cnt <= 4'h0;
            if (sync_mode) begin
              // idle fill with first sync char
              tx_line <= tx_full ? tx_hold[0] : sync_first[0];
              tx_shift <= {2'b11, tx_full ? tx_hold[7:1] : sync_first[7:1]};
              tx_left <= `MCUP_BITS_SYNC;
            end else begin
              tx_line <= 1'b0;
              tx_shift <= {1'b1, tx_hold};
              tx_left <= `MCUP_BITS_ASYNC;
            end
          end else if (tx_busy && tx_bit) begin
            if (tx_left != 4'h0) begin
              tx_line <= tx_shift[0];
              tx_shift <= {1'b1, tx_shift[8:1]};
              tx_left <= tx_left - 4'h1;
            end else begin
              tx_busy <= 1'b0;
              if (!sync_mode)
                tx_line <= 1'b1;
            end
          end
          // a host write refills the holder even when full, and wins over a load
          if (wr && sel == `MCUP_SEL_DATA)
            tx_full <= 1'b1;
          else if (tx_go)
            tx_full <= 1'b0;
        end
      end

      assign SERIAL_OUT[i] = tx_line;
      assign TERMINAL_READY_OUT[i] = ~cmd[`MCUP_CMD_DTR];
      assign REQUEST_TO_SEND_OUT[i] = ~cmd[`MCUP_CMD_RTS];
      assign RECEIVE_READY_OUT[i] = ~status[`MCUP_ST_RECEIVE_READY_OUT];
      assign TRANSMIT_READY_OUT[i] = ~status[`MCUP_ST_TRANSMIT_READY_OUT];
    end
  endgenerate

  // Read data latched at the start of a read cycle
  integer k;
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      CHANNEL_DATA_BUS_OUT <= 8'h00;
    end else begin
      for (k = 0; k < `MCUP_CHANNELS; k = k + 1) begin
        if (rd_start[k])
          CHANNEL_DATA_BUS_OUT <= rd_flat[8*k +: 8];
      end
    end
  end
  assign CHANNEL_DATA_BUS_OE = ~READ_STROBE_N & ~(&CHIP_ENABLE_N);

  assign PROCESSOR_SERIAL_IN = SERIAL_IN[`MCUP_CH_CONSOLE];
  assign AUTOBAUD_ENABLE = DATA_SET_READY[`MCUP_CH_CONSOLE];
  assign FACTORY_TEST_MODE = ~DATA_SET_READY[`MCUP_CH_MODEM];
  assign INDICATOR_ONE_LIT = ~TERMINAL_READY_OUT[`MCUP_CH_PRINTER];
  assign INDICATOR_TWO_LIT = ~REQUEST_TO_SEND_OUT[`MCUP_CH_PRINTER];

  // Run indicator one-shot
  reg [31:0] run_cnt;
  always @(posedge CLOCK) begin
    if (SYS_RST)
      run_cnt <= 32'h00000000;
    else if (act_prev && !BUS_ACTIVITY_PULSE_N)
      run_cnt <= RUN_HOLD_CYCLES;
    else if (run_cnt != 32'h00000000)
      run_cnt <= run_cnt - 32'h00000001;
  end
  assign RUN_INDICATOR = (run_cnt != 32'h00000000);

endmodule

// file: mcup_port_properties.sv
// Purpose: Pin-level checks for the serial port bank
// Assumes: One clock domain, synchronous active-high reset
// Notes: Channel 0 stands in for the per-channel register checks
module mcup_port_chk #(
  parameter RUN_HOLD_CYCLES = 20
) (
  input wire CLOCK,
  input wire SYS_RST,
  input wire [5:0] CHIP_ENABLE_N,
  input wire DIRECTION_SELECT,
  input wire REGISTER_SELECT_HIGH,
  input wire REGISTER_SELECT_LOW,
  input wire READ_STROBE_N,
  input wire WRITE_STROBE_N,
  input wire [7:0] CHANNEL_DATA_BUS_IN,
  input wire [7:0] CHANNEL_DATA_BUS_OUT,
  input wire CHANNEL_DATA_BUS_OE,
  input wire [5:0] SERIAL_IN,
  input wire [5:0] DATA_SET_READY,
  input wire [5:0] TERMINAL_READY_OUT,
  input wire [5:0] REQUEST_TO_SEND_OUT,
  input wire [5:0] RECEIVE_READY_OUT,
  input wire [5:0] TRANSMIT_READY_OUT,
  input wire PROCESSOR_SERIAL_IN,
  input wire AUTOBAUD_ENABLE,
  input wire FACTORY_TEST_MODE,
  input wire INDICATOR_ONE_LIT,
  input wire INDICATOR_TWO_LIT,
  input wire BUS_ACTIVITY_PULSE_N,
  input wire RUN_INDICATOR
);
  // Any channel access in progress
  wire acc = ~&CHIP_ENABLE_N & ~(READ_STROBE_N & WRITE_STROBE_N);
  reg act_prev;
  reg [31:0] since_fall;
  // Cycles since the last activity fall, saturating
  always @(posedge CLOCK) begin
    act_prev <= BUS_ACTIVITY_PULSE_N;
    if (SYS_RST)
      since_fall <= RUN_HOLD_CYCLES + 8;
    else if (act_prev & ~BUS_ACTIVITY_PULSE_N)
      since_fall <= 32'h0;
    else if (since_fall < RUN_HOLD_CYCLES + 8)
      since_fall <= since_fall + 32'h1;
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  sequence s_take;
    acc && !$past(acc);
  endsequence
  sequence s_status_read0;
    s_take ##0 (!CHIP_ENABLE_N[0] && !READ_STROBE_N && !DIRECTION_SELECT && !REGISTER_SELECT_HIGH && REGISTER_SELECT_LOW);
  endsequence
  sequence s_command_write0;
    s_take ##0 (!CHIP_ENABLE_N[0] && !WRITE_STROBE_N && DIRECTION_SELECT && REGISTER_SELECT_HIGH && REGISTER_SELECT_LOW);
  endsequence
  property p_reset_clear;
    disable iff (1'b0) SYS_RST |=> (TERMINAL_READY_OUT == 6'h3f && REQUEST_TO_SEND_OUT == 6'h3f &&
      RECEIVE_READY_OUT == 6'h3f && TRANSMIT_READY_OUT == 6'h00 && !RUN_INDICATOR);
  endproperty
  property p_status_read;
    s_status_read0 |=> (CHANNEL_DATA_BUS_OUT[7] == !$past(DATA_SET_READY[0])) &&
      (CHANNEL_DATA_BUS_OUT[1] == !$past(RECEIVE_READY_OUT[0])) && (CHANNEL_DATA_BUS_OUT[0] == !$past(TRANSMIT_READY_OUT[0]));
  endproperty
  property p_command_write;
    s_command_write0 |=> (TERMINAL_READY_OUT[0] == !$past(CHANNEL_DATA_BUS_IN[1])) &&
      (REQUEST_TO_SEND_OUT[0] == !$past(CHANNEL_DATA_BUS_IN[5]));
  endproperty
  property p_hold_data;
    !(acc && !$past(acc) && !READ_STROBE_N) |=> $stable(CHANNEL_DATA_BUS_OUT);
  endproperty
  property p_bus_dir;
    CHANNEL_DATA_BUS_OE == (!READ_STROBE_N && !(&CHIP_ENABLE_N));
  endproperty
  property p_straps;
    (AUTOBAUD_ENABLE == DATA_SET_READY[0]) && (FACTORY_TEST_MODE == !DATA_SET_READY[1]);
  endproperty
  property p_proc_in;
    PROCESSOR_SERIAL_IN == SERIAL_IN[0];
  endproperty
  property p_lamps;
    (INDICATOR_ONE_LIT == !TERMINAL_READY_OUT[2]) && (INDICATOR_TWO_LIT == !REQUEST_TO_SEND_OUT[2]);
  endproperty
  property p_run_on;
    $fell(BUS_ACTIVITY_PULSE_N) |-> ##2 RUN_INDICATOR [*8];
  endproperty
  property p_run_off;
    since_fall > RUN_HOLD_CYCLES + 3 |-> !RUN_INDICATOR;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset state wrong");
  a_status_read: assert property (p_status_read) else $error("status bits wrong");
  a_command_write: assert property (p_command_write) else $error("modem outputs wrong");
  a_hold_data: assert property (p_hold_data) else $error("read data moved");
  a_bus_dir: assert property (p_bus_dir) else $error("bus direction wrong");
  a_straps: assert property (p_straps) else $error("strap outputs wrong");
  a_proc_in: assert property (p_proc_in) else $error("processor input wrong");
  a_lamps: assert property (p_lamps) else $error("lamps wrong");
  a_run_on: assert property (p_run_on) else $error("run lamp not lit");
  a_run_off: assert property (p_run_off) else $error("run lamp stuck");
endmodule
bind mcup_port mcup_port_chk #(.RUN_HOLD_CYCLES(RUN_HOLD_CYCLES)) u_chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
  .CHIP_ENABLE_N(CHIP_ENABLE_N), .DIRECTION_SELECT(DIRECTION_SELECT), .REGISTER_SELECT_HIGH(REGISTER_SELECT_HIGH),
  .REGISTER_SELECT_LOW(REGISTER_SELECT_LOW), .READ_STROBE_N(READ_STROBE_N), .WRITE_STROBE_N(WRITE_STROBE_N),
  .CHANNEL_DATA_BUS_IN(CHANNEL_DATA_BUS_IN), .CHANNEL_DATA_BUS_OUT(CHANNEL_DATA_BUS_OUT),
  .CHANNEL_DATA_BUS_OE(CHANNEL_DATA_BUS_OE), .SERIAL_IN(SERIAL_IN), .DATA_SET_READY(DATA_SET_READY),
  .TERMINAL_READY_OUT(TERMINAL_READY_OUT), .REQUEST_TO_SEND_OUT(REQUEST_TO_SEND_OUT),
  .RECEIVE_READY_OUT(RECEIVE_READY_OUT), .TRANSMIT_READY_OUT(TRANSMIT_READY_OUT),
  .PROCESSOR_SERIAL_IN(PROCESSOR_SERIAL_IN), .AUTOBAUD_ENABLE(AUTOBAUD_ENABLE), .FACTORY_TEST_MODE(FACTORY_TEST_MODE),
  .INDICATOR_ONE_LIT(INDICATOR_ONE_LIT), .INDICATOR_TWO_LIT(INDICATOR_TWO_LIT),
  .BUS_ACTIVITY_PULSE_N(BUS_ACTIVITY_PULSE_N), .RUN_INDICATOR(RUN_INDICATOR));

// file: multi_channel_usart_port_tb.sv
// Purpose: Self-checking bench for the serial port bank
// Assumes: Reference clock sped up so a character takes about ten thousand cycles
// Notes: Table rows cover register access; straps, run lamp and serial traffic follow by hand
module multi_channel_usart_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [2:0] ch; logic wr; logic [1:0] sel; logic [7:0] data; logic [7:0] exp;} mcup_row_t;
  localparam int HOLD = 20;
  localparam logic [7:0] SYNC_CHAR = 8'h96;
  localparam int ROWS = 15;
  localparam mcup_row_t TABLE [ROWS] = '{
    '{3'd0, 1'b0, 2'b11, 8'h00, 8'h00}, '{3'd0, 1'b0, 2'b01, 8'h00, 8'h05}, '{3'd1, 1'b0, 2'b01, 8'h00, 8'h85},
    '{3'd0, 1'b1, 2'b11, 8'h22, 8'h00}, '{3'd0, 1'b0, 2'b11, 8'h00, 8'h22}, '{3'd2, 1'b1, 2'b11, 8'h02, 8'h00},
    '{3'd2, 1'b0, 2'b11, 8'h00, 8'h02}, '{3'd5, 1'b1, 2'b11, 8'h20, 8'h00}, '{3'd1, 1'b1, 2'b10, 8'h5a, 8'h00},
    '{3'd1, 1'b1, 2'b10, 8'h06, 8'h00}, '{3'd1, 1'b0, 2'b11, 8'h00, 8'h00}, '{3'd1, 1'b0, 2'b10, 8'h00, 8'h5a},
    '{3'd1, 1'b0, 2'b10, 8'h00, 8'h06}, '{3'd3, 1'b1, 2'b01, 8'h16, 8'h00}, '{3'd4, 1'b0, 2'b10, 8'h00, 8'h00}};
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, sel_hi = 1'b0, sel_lo = 1'b0, rd_n = 1'b1, wr_n = 1'b1;
  logic ref_clk = 1'b0, act_n = 1'b1, oe, proc_in, autobaud, factory, ind1, ind2, run, ok, sync_receive_clock = 1'b0;
  logic [5:0] ce_n = 6'h3f, dsr = 6'h05, cts_n = 6'h00, ser_out, dtr, rts, rxr, txr;
  wire [5:0] ser_in;
  logic [7:0] din = 8'h00, dout, rdata;
  int failures = 0, comparisons = 0, cycles = 0;
  mcup_row_t r;
  mcup_port #(.RUN_HOLD_CYCLES(HOLD)) uut (
    .CLOCK(clk), .SYS_RST(rst), .CHIP_ENABLE_N(ce_n), .DIRECTION_SELECT(wr), .REGISTER_SELECT_HIGH(sel_hi),
    .REGISTER_SELECT_LOW(sel_lo), .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n), .CHANNEL_DATA_BUS_IN(din),
    .CHANNEL_DATA_BUS_OUT(dout), .CHANNEL_DATA_BUS_OE(oe), .BAUD_REFERENCE_CLOCK(ref_clk),
    .SYNC_RECEIVE_CLOCK(sync_receive_clock), .SYNC_TRANSMIT_CLOCK(1'b0), .SERIAL_IN(ser_in), .SERIAL_OUT(ser_out),
    .DATA_SET_READY(dsr), .CLEAR_TO_SEND_N(cts_n), .TERMINAL_READY_OUT(dtr), .REQUEST_TO_SEND_OUT(rts),
    .RECEIVE_READY_OUT(rxr), .TRANSMIT_READY_OUT(txr), .PROCESSOR_SERIAL_IN(proc_in), .AUTOBAUD_ENABLE(autobaud),
    .FACTORY_TEST_MODE(factory), .INDICATOR_ONE_LIT(ind1), .INDICATOR_TWO_LIT(ind2),
    .BUS_ACTIVITY_PULSE_N(act_n), .RUN_INDICATOR(run));
  mcup_peer peer (.line_from_dut(ser_out), .line_to_dut(ser_in));
  // System clock, 4 ns period
  initial forever #2 clk = ~clk;
  // Baud reference, sped up to keep characters short
  initial forever #4 ref_clk = ~ref_clk;
  // Cycle ceiling against hangs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 50000) begin
      failures++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One register cycle: taken at the first edge, released after it, data read a cycle later
  task automatic access(input mcup_row_t a, output logic [7:0] rd);
    @(posedge clk);
    #1;
    ce_n[a.ch] = 1'b0;
    {wr, sel_hi, sel_lo, din} = {a.wr, a.sel, a.data};
    {rd_n, wr_n} = {a.wr, ~a.wr};
    @(posedge clk);
    chk({7'h0, oe}, {7'h0, ~a.wr});
    #1;
    {ce_n, rd_n, wr_n} = {6'h3f, 2'b11};
    @(posedge clk);
    #1;
    rd = dout;
  endtask
  // One-cycle low pulse on bus activity
  task automatic pulse();
    @(posedge clk);
    #1 act_n = 1'b0;
    @(posedge clk);
    #1 act_n = 1'b1;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    chk(dout, 8'h00);
    chk({2'h0, dtr}, 8'h3f);
    chk({2'h0, rxr}, 8'h3f);
    chk({2'h0, txr}, 8'h00);
    chk({5'h0, run, autobaud, factory}, 8'h03);
    for (int i = 0; i < ROWS; i++) begin
      r = TABLE[i];
      access(r, rdata);
      if (!r.wr)
        chk(rdata, r.exp);
      if (r.wr && r.sel == 2'b11)
        chk({6'h0, dtr[r.ch], rts[r.ch]}, {6'h0, ~r.data[1], ~r.data[5]});
    end
    chk({6'h0, ind1, ind2}, 8'h02);
    dsr = 6'h06;
    #1 chk({6'h0, autobaud, factory}, 8'h00);
    access('{3'd0, 1'b0, 2'b01, 8'h00, 8'h00}, rdata);
    chk(rdata, 8'h85);
    pulse();
    repeat (3) @(posedge clk);
    #1 chk({7'h0, run}, 8'h01);
    repeat (3) begin
      repeat (HOLD - 8) @(posedge clk);
      pulse();
    end
    #1 chk({7'h0, run}, 8'h01);
    repeat (HOLD + 6) @(posedge clk);
    #1 chk({7'h0, run}, 8'h00);
    pulse();
    rst = 1'b1;
    @(posedge clk);
    #1 rst = 1'b0;
    chk({7'h0, run}, 8'h00);
    chk({2'h0, dtr}, 8'h3f);
    access('{3'd0, 1'b1, 2'b10, 8'h02, 8'h00}, rdata);
    access('{3'd0, 1'b1, 2'b10, 8'h07, 8'h00}, rdata);
    access('{3'd0, 1'b1, 2'b11, 8'h05, 8'h00}, rdata);
    peer.send_char(0, 8'ha5);
    for (int i = 0; i < 2000 && rxr[0] !== 1'b0; i++)
      @(posedge clk);
    #1 chk({7'h0, rxr[0]}, 8'h00);
    access('{3'd0, 1'b0, 2'b00, 8'h00, 8'h00}, rdata);
    chk(rdata, 8'ha5);
    chk({7'h0, rxr[0]}, 8'h01);
    cts_n[0] = 1'b1;
    access('{3'd0, 1'b1, 2'b00, 8'h3c, 8'h00}, rdata);
    chk({7'h0, txr[0]}, 8'h01);
    repeat (3000) @(posedge clk);
    #1 chk({7'h0, ser_out[0]}, 8'h01);
    cts_n[0] = 1'b0;
    peer.get_char(0, rdata, ok);
    chk(rdata, 8'h3c);
    chk({6'h0, ok, txr[0]}, 8'h02);
    // Modem channel is synchronous after reset: eight receive clock edges make a character
    access('{3'd1, 1'b1, 2'b11, 8'h04, 8'h00}, rdata);
    for (int i = 0; i < 8; i++) begin
      peer.drive(1, SYNC_CHAR[i]);
      @(posedge clk);
      #1 sync_receive_clock = 1'b1;
      @(posedge clk);
      #1 sync_receive_clock = 1'b0;
    end
    peer.drive(1, 1'b1);
    chk({7'h0, rxr[1]}, 8'h00);
    access('{3'd1, 1'b0, 2'b00, 8'h00, 8'h00}, rdata);
    chk(rdata, SYNC_CHAR);
    end_sim();
  end
endmodule
